/* File: design/sfe_pkg.sv */
// shared opcodes, sizes and frame constants for the serial flash erase/program link
package sfe_pkg;
	localparam logic [7:0] OP_PAGE_ERASE       = 8'h81;
	localparam logic [7:0] OP_SECTOR_ERASE     = 8'h20;
	localparam logic [7:0] OP_HALF_BLOCK_ERASE = 8'h52;
	localparam logic [7:0] OP_BLOCK_ERASE      = 8'hd8;
	localparam logic [7:0] OP_CHIP_ERASE_A     = 8'h60;
	localparam logic [7:0] OP_CHIP_ERASE_B     = 8'hc7;
	localparam logic [7:0] OP_PAGE_WRITE       = 8'h02;
	localparam logic [7:0] OP_TWO_LINE_WRITE   = 8'ha2;
	localparam logic [7:0] OP_WRITE_ENABLE     = 8'h06;
	localparam logic [7:0] OP_READ_STATUS      = 8'h05;
	localparam int         PAGE_BYTES          = 256;
	localparam int         SECTOR_BYTES        = 4096;
	localparam int         HALF_BLOCK_BYTES    = 32768;
	localparam int         BLOCK_BYTES         = 65536;
	localparam int         BP_W                = 5;
	localparam logic [4:0] BP_ALL_CODE         = 5'h0d;
	localparam int         ST_WIP              = 0;
	localparam int         ST_WEL              = 1;
	localparam logic [7:0] ERASED_BYTE         = 8'hff;
	localparam logic [2:0] CMD_END             = 3'h1;
	localparam logic [2:0] ADDR_END            = 3'h4;
	localparam logic [2:0] PROG_MIN            = 3'h5;
	localparam int         ADDR_BYTES          = 3;
endpackage : sfe_pkg

/* File: design/sfe_link_if.sv */
// four-wire serial flash link between host controller and flash device
`timescale 1ns/1ps
interface sfe_link_if;
	logic       sclk;      // serial clock from host
	logic       csN;       // chip select, active low
	logic [3:0] hostSio;   // host drive values
	logic [3:0] hostSioOe; // host drive enables
	logic [3:0] devSio;    // device drive values
	logic [3:0] devSioOe;  // device drive enables
	logic [3:0] sio;       // resolved data lines
	// undriven lines float high through the board pull-ups
	for (genvar i = 0; i < 4; i++)
	begin : g_res
		assign sio[i] = devSioOe[i] ? devSio[i] : (hostSioOe[i] ? hostSio[i] : 1'b1);
	end
	modport host (output sclk, output csN, output hostSio, output hostSioOe, input sio);
	modport dev  (input sclk, input csN, input sio, output devSio, output devSioOe);
endinterface : sfe_link_if

/* File: design/sfe_flash_dev.sv */
// flash device end: command decode, page buffer, self-timed erase/program engine, array
`timescale 1ns/1ps
// Functional notes
// - page erase 81h sets one 256-byte page
// - erase/program need write enable latch set
// - sector erase selects sector from A12 up
// - erase rejected unless chip select rises on boundary
// - sector erase busy, then latch cleared
// - protected sector is not erased
// - 52h erases containing 32K block
// - 32K erase busy; protected keeps array, clears latch
// - D8h erases containing 64K block
// - 64K erase self-timed, protected block untouched
// - chip erase 60h/C7h, opcode only
// - chip erase only with no protection
// - page write 02h programs bits toward zero
// - data past page end wraps to start
// - only final 256 bytes are kept
// - short program leaves other bytes unchanged
// - program chip select rises after data byte
// - program self-timed, protected page untouched
// - upper data lines ignored
// - A2h takes data two bits per clock
// - erase to ones, program only clears bits
module sfe_flash_dev
#(
	parameter int ADDR_W = 16 // array address width, at least 16
)
(
	input  wire logic                      clk_sys,      // system clock
	input  wire logic                      rst,          // async reset, active high
	sfe_link_if.dev                        link,         // serial link
	input  wire logic [sfe_pkg::BP_W-1:0]  blockProtect, // block protect bits
	input  wire logic [ADDR_W-1:0]         peekAddr,     // array peek address
	output logic      [7:0]                peekData,     // array byte, one cycle late
	output logic                           wipFlag,      // write in progress
	output logic                           welFlag       // write enable latch
);
	localparam int MEM_BYTES = 1 << ADDR_W;

	logic [2:0]          sclkSync_r;
	logic [2:0]          csSync_r;
	logic [1:0]          sioM_r;
	logic [1:0]          sioS_r;
	logic [7:0]          shift_r;
	logic [2:0]          bitIdx_r;
	logic [2:0]          byteCnt_r;
	logic [7:0]          opcode_r;
	logic [23:0]         addr_r;
	logic [7:0]          dataCnt_r;
	logic                accept_r;
	logic [7:0]          pageBuf [sfe_pkg::PAGE_BYTES];
	logic [255:0]        pageMask_r;
	logic [7:0]          mem [MEM_BYTES];
	logic                busy_r;
	logic                inhibit_r;
	logic                progOp_r;
	logic [ADDR_W-1:0]   ptr_r;
	logic [ADDR_W-1:0]   left_r;
	logic                wel_r;
	logic                sioOut_r;
	logic                sioOe_r;
	logic                selected;
	logic                sclkRise;
	logic                sclkFall;
	logic                csRise;
	logic                csFall;
	logic                dataPhase;
	logic                dualNow;
	logic                byteDone;
	logic                isProg;
	logic [7:0]          shiftNxt;
	logic [2:0]          bitNxt;
	logic [7:0]          bufIdx;
	logic [7:0]          statByte;
	logic                lenOk;
	logic                isProtected;
	logic                startOp;
	logic                wrenOk;
	logic [31:0]         regionSize;
	logic [31:0]         regionBase;
	logic [31:0]         regionEnd;
	logic [31:0]         protBytes;

	// pins cross two flops; edges are found on the second and third
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			sclkSync_r <= 3'h0;
			csSync_r   <= 3'h7;
			sioM_r     <= 2'h3;
			sioS_r     <= 2'h3;
		end
		else
		begin
			sclkSync_r <= {sclkSync_r[1:0], link.sclk};
			csSync_r   <= {csSync_r[1:0], link.csN};
			sioM_r     <= link.sio[1:0];
			sioS_r     <= sioM_r;
		end
	end

	assign selected = ~csSync_r[1];
	assign sclkRise = sclkSync_r[1] & ~sclkSync_r[2];
	assign sclkFall = ~sclkSync_r[1] & sclkSync_r[2];
	assign csRise   = csSync_r[1] & ~csSync_r[2];
	assign csFall   = ~csSync_r[1] & csSync_r[2];
	assign isProg   = (opcode_r == sfe_pkg::OP_PAGE_WRITE)
	                || (opcode_r == sfe_pkg::OP_TWO_LINE_WRITE);

	always_comb
	begin
		dataPhase = (byteCnt_r >= sfe_pkg::ADDR_END);
		dualNow   = dataPhase && (opcode_r == sfe_pkg::OP_TWO_LINE_WRITE);
		shiftNxt  = dualNow ? {shift_r[5:0], sioS_r[1], sioS_r[0]}
		                    : {shift_r[6:0], sioS_r[0]};
		bitNxt    = bitIdx_r + (dualNow ? 3'h2 : 3'h1);
		byteDone  = sclkRise && selected && (bitNxt == 3'h0);
		bufIdx    = addr_r[7:0] + dataCnt_r;
	end

	// frame shifter: opcode, three address bytes, then data
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			shift_r   <= 8'h00;
			bitIdx_r  <= 3'h0;
			byteCnt_r <= 3'h0;
			opcode_r  <= 8'h00;
			addr_r    <= 24'h000000;
			dataCnt_r <= 8'h00;
			accept_r  <= 1'b0;
		end
		else if (csFall)
		begin
			bitIdx_r  <= 3'h0;
			byteCnt_r <= 3'h0;
			dataCnt_r <= 8'h00;
			accept_r  <= ~busy_r;
		end
		else if (sclkRise && selected)
		begin
			shift_r  <= shiftNxt;
			bitIdx_r <= bitNxt;
			if (byteDone)
			begin
				if (byteCnt_r != sfe_pkg::PROG_MIN)
					byteCnt_r <= byteCnt_r + 3'h1;
				if (byteCnt_r == 3'h0)
					opcode_r <= shiftNxt;
				else if (!dataPhase)
					addr_r <= {addr_r[15:0], shiftNxt};
				else
					dataCnt_r <= dataCnt_r + 8'h01;
			end
		end
	end

	// later bytes overwrite earlier ones at the same wrapped slot
	always_ff @(posedge clk_sys)
	begin
		if (byteDone && dataPhase && isProg && accept_r)
			pageBuf[bufIdx] <= shiftNxt;
	end

	// the mask must survive a frame that arrives while the engine runs
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			pageMask_r <= '0;
		else if (csFall && !busy_r)
			pageMask_r <= '0;
		else if (byteDone && dataPhase && isProg && accept_r)
			pageMask_r[bufIdx] <= 1'b1;
	end

	// decode the finished frame at the rise of chip select
	always_comb
	begin
		lenOk      = 1'b0;
		regionSize = 32'(sfe_pkg::PAGE_BYTES);
		case (opcode_r)
			sfe_pkg::OP_PAGE_ERASE:
				lenOk = (byteCnt_r == sfe_pkg::ADDR_END);
			sfe_pkg::OP_SECTOR_ERASE:
			begin
				lenOk      = (byteCnt_r == sfe_pkg::ADDR_END);
				regionSize = 32'(sfe_pkg::SECTOR_BYTES);
			end
			sfe_pkg::OP_HALF_BLOCK_ERASE:
			begin
				lenOk      = (byteCnt_r == sfe_pkg::ADDR_END);
				regionSize = 32'(sfe_pkg::HALF_BLOCK_BYTES);
			end
			sfe_pkg::OP_BLOCK_ERASE:
			begin
				lenOk      = (byteCnt_r == sfe_pkg::ADDR_END);
				regionSize = 32'(sfe_pkg::BLOCK_BYTES);
			end
			sfe_pkg::OP_CHIP_ERASE_A, sfe_pkg::OP_CHIP_ERASE_B:
			begin
				lenOk      = (byteCnt_r == sfe_pkg::CMD_END);
				regionSize = 32'(MEM_BYTES);
			end
			sfe_pkg::OP_PAGE_WRITE, sfe_pkg::OP_TWO_LINE_WRITE:
				lenOk = (byteCnt_r == sfe_pkg::PROG_MIN);
			default:
				lenOk = 1'b0;
		endcase
		if (regionSize > 32'(MEM_BYTES))
			regionSize = 32'(MEM_BYTES);
		regionBase = {8'h00, addr_r} & ~(regionSize - 32'h1) & 32'(MEM_BYTES - 1);
		regionEnd  = regionBase + regionSize - 32'h1;
		// protection covers the top of the array, growing with the code
		if (blockProtect >= sfe_pkg::BP_ALL_CODE)
			protBytes = 32'(MEM_BYTES);
		else
			protBytes = 32'(sfe_pkg::SECTOR_BYTES) << (blockProtect - 5'h1);
		if (protBytes > 32'(MEM_BYTES))
			protBytes = 32'(MEM_BYTES);
		isProtected = (blockProtect != 5'h00)
		            && (regionEnd >= 32'(MEM_BYTES) - protBytes);
		startOp = csRise && (bitIdx_r == 3'h0) && lenOk && wel_r
		        && accept_r && !busy_r;
		wrenOk  = csRise && (bitIdx_r == 3'h0) && (byteCnt_r == sfe_pkg::CMD_END)
		        && (opcode_r == sfe_pkg::OP_WRITE_ENABLE) && !busy_r;
	end

	// self-timed engine: one array byte per cycle across the region
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			busy_r    <= 1'b0;
			inhibit_r <= 1'b0;
			progOp_r  <= 1'b0;
			ptr_r     <= '0;
			left_r    <= '0;
		end
		else if (startOp)
		begin
			busy_r    <= 1'b1;
			inhibit_r <= isProtected;
			progOp_r  <= isProg;
			ptr_r     <= regionBase[ADDR_W-1:0];
			left_r    <= ADDR_W'(regionSize - 32'h1);
		end
		else if (busy_r)
		begin
			if (left_r == '0)
				busy_r <= 1'b0;
			else
			begin
				ptr_r  <= ptr_r + 1'b1;
				left_r <= left_r - 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (busy_r && !inhibit_r)
		begin
			if (!progOp_r)
				mem[ptr_r] <= sfe_pkg::ERASED_BYTE;
			else if (pageMask_r[ptr_r[7:0]])
				mem[ptr_r] <= mem[ptr_r] & pageBuf[ptr_r[7:0]];
		end
		peekData <= mem[peekAddr];
	end

	// latch drops as the cycle ends; an enable is refused while busy, so none wins that cycle
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			wel_r <= 1'b0;
		else
		begin
			if (busy_r && (left_r == '0))
				wel_r <= 1'b0;
			if (wrenOk)
				wel_r <= 1'b1;
		end
	end

	always_comb
	begin
		statByte                  = 8'h00;
		statByte[sfe_pkg::ST_WIP] = busy_r;
		statByte[sfe_pkg::ST_WEL] = wel_r;
	end

	// status shifts out on the falling edge, repeating every byte
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			sioOut_r <= 1'b0;
			sioOe_r  <= 1'b0;
		end
		else if (!selected)
			sioOe_r <= 1'b0;
		else if (sclkFall && (opcode_r == sfe_pkg::OP_READ_STATUS) && (byteCnt_r != 3'h0))
		begin
			sioOut_r <= statByte[3'h7 - bitIdx_r];
			sioOe_r  <= 1'b1;
		end
	end

	assign link.devSio   = {2'b00, sioOut_r, 1'b0};
	assign link.devSioOe = {2'b00, sioOe_r, 1'b0};
	assign wipFlag       = busy_r;
	assign welFlag       = wel_r;
endmodule : sfe_flash_dev

/* File: design/sfe_flash_host.sv */
// host controller end: frames commands onto the serial flash link
`timescale 1ns/1ps
module sfe_flash_host
#(
	parameter int HALF_DIV = 8 // clk_sys cycles per sclk half period
)
(
	input  wire logic        clk_sys,  // system clock
	input  wire logic        rst,      // async reset, active high
	sfe_link_if.host         link,     // serial link
	input  wire logic        cmdValid, // command request
	output logic             cmdReady, // idle, command taken when valid
	input  wire logic [7:0]  cmdOp,    // opcode
	input  wire logic [23:0] cmdAddr,  // byte address
	input  wire logic [8:0]  cmdLen,   // data bytes for program
	output logic             wrTake,   // pulse: wrData consumed
	input  wire logic [7:0]  wrData,   // program data byte
	output logic             rdValid,  // pulse: status byte ready
	output logic [7:0]       rdData    // status byte
);
	typedef enum {H_IDLE, H_LOAD, H_LOW, H_HIGH, H_END, H_GAP} sfe_hstate_t;

	sfe_hstate_t state_r;
	logic [7:0]  halfCnt_r;
	logic [7:0]  op_r;
	logic [23:0] addr_r;
	logic [9:0]  byteIdx_r;
	logic [9:0]  total_r;
	logic        hasAddr_r;
	logic        isProg_r;
	logic [7:0]  shift_r;
	logic [7:0]  inShift_r;
	logic [3:0]  bitsLeft_r;
	logic        dual_r;
	logic        sclk_r;
	logic        csN_r;
	logic        sioM_r;
	logic        sioS_r;
	logic        halfDone;
	logic        needAddr;
	logic        progCmd;
	logic        dataByte;
	logic [3:0]  step;
	logic [9:0]  totalNxt;
	logic [7:0]  nextByte;

	always_comb
	begin
		halfDone = (halfCnt_r == 8'(HALF_DIV - 1));
		progCmd  = (cmdOp == sfe_pkg::OP_PAGE_WRITE) || (cmdOp == sfe_pkg::OP_TWO_LINE_WRITE);
		needAddr = progCmd || (cmdOp == sfe_pkg::OP_PAGE_ERASE)
		        || (cmdOp == sfe_pkg::OP_SECTOR_ERASE)
		        || (cmdOp == sfe_pkg::OP_HALF_BLOCK_ERASE)
		        || (cmdOp == sfe_pkg::OP_BLOCK_ERASE);
		totalNxt = 10'h001 + (needAddr ? 10'(sfe_pkg::ADDR_BYTES) : 10'h000)
		         + (progCmd ? {1'b0, cmdLen} : 10'h000)
		         + ((cmdOp == sfe_pkg::OP_READ_STATUS) ? 10'h001 : 10'h000);
		dataByte = isProg_r && (byteIdx_r >= 10'(sfe_pkg::ADDR_END));
		case (byteIdx_r)
			10'h000: nextByte = op_r;
			10'h001: nextByte = hasAddr_r ? addr_r[23:16] : 8'h00;
			10'h002: nextByte = hasAddr_r ? addr_r[15:8] : 8'h00;
			10'h003: nextByte = hasAddr_r ? addr_r[7:0] : 8'h00;
			default: nextByte = dataByte ? wrData : 8'h00;
		endcase
		step = dual_r ? 4'h2 : 4'h1;
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			sioM_r <= 1'b1;
			sioS_r <= 1'b1;
		end
		else
		begin
			sioM_r <= link.sio[1];
			sioS_r <= sioM_r;
		end
	end

	// each frame ends on a byte boundary before chip select rises
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			state_r    <= H_IDLE;
			halfCnt_r  <= 8'h00;
			op_r       <= 8'h00;
			addr_r     <= 24'h000000;
			byteIdx_r  <= 10'h000;
			total_r    <= 10'h000;
			hasAddr_r  <= 1'b0;
			isProg_r   <= 1'b0;
			shift_r    <= 8'h00;
			inShift_r  <= 8'h00;
			bitsLeft_r <= 4'h0;
			dual_r     <= 1'b0;
			sclk_r     <= 1'b0;
			csN_r      <= 1'b1;
			rdValid    <= 1'b0;
			rdData     <= 8'h00;
		end
		else
		begin
			rdValid <= 1'b0;
			case (state_r)
				H_IDLE:
					if (cmdValid)
					begin
						op_r      <= cmdOp;
						addr_r    <= cmdAddr;
						hasAddr_r <= needAddr;
						isProg_r  <= progCmd;
						total_r   <= totalNxt;
						byteIdx_r <= 10'h000;
						dual_r    <= 1'b0; // stale dual mode would drive sio1 before the opcode
						csN_r     <= 1'b0;
						state_r   <= H_LOAD;
					end
				H_LOAD:
				begin
					shift_r    <= nextByte;
					bitsLeft_r <= 4'h8;
					dual_r     <= dataByte && (op_r == sfe_pkg::OP_TWO_LINE_WRITE);
					halfCnt_r  <= 8'h00;
					state_r    <= H_LOW;
				end
				H_LOW:
					if (halfDone)
					begin
						sclk_r    <= 1'b1;
						inShift_r <= {inShift_r[6:0], sioS_r};
						halfCnt_r <= 8'h00;
						state_r   <= H_HIGH;
					end
					else
						halfCnt_r <= halfCnt_r + 8'h01;
				H_HIGH:
					if (halfDone)
					begin
						sclk_r     <= 1'b0;
						halfCnt_r  <= 8'h00;
						shift_r    <= dual_r ? {shift_r[5:0], 2'b00} : {shift_r[6:0], 1'b0};
						bitsLeft_r <= bitsLeft_r - step;
						if (bitsLeft_r == step)
						begin
							byteIdx_r <= byteIdx_r + 10'h001;
							if (op_r == sfe_pkg::OP_READ_STATUS && byteIdx_r == 10'h001)
							begin
								rdValid <= 1'b1;
								rdData  <= inShift_r;
							end
							state_r <= (byteIdx_r == total_r - 10'h001) ? H_END : H_LOAD;
						end
						else
							state_r <= H_LOW;
					end
					else
						halfCnt_r <= halfCnt_r + 8'h01;
				H_END:
					if (halfDone)
					begin
						csN_r     <= 1'b1;
						halfCnt_r <= 8'h00;
						state_r   <= H_GAP;
					end
					else
						halfCnt_r <= halfCnt_r + 8'h01;
				H_GAP:
					if (halfDone)
						state_r <= H_IDLE;
					else
						halfCnt_r <= halfCnt_r + 8'h01;
				default:
					state_r <= H_IDLE;
			endcase
		end
	end

	assign cmdReady       = (state_r == H_IDLE);
	assign wrTake         = (state_r == H_LOAD) && dataByte;
	assign link.sclk      = sclk_r;
	assign link.csN       = csN_r;
	assign link.hostSio   = {2'b00, shift_r[7], dual_r ? shift_r[6] : shift_r[7]};
	assign link.hostSioOe = {2'b00, ~csN_r & dual_r, ~csN_r};
endmodule : sfe_flash_host

/* File: bench/sfe_link_asserts.sv */
// wire-level checks on the serial flash link
`timescale 1ns/1ps
module sfe_link_asserts
(
	input wire logic       clk_sys,   // system clock
	input wire logic       rst,       // async reset, active high
	input wire logic       sclk,      // serial clock
	input wire logic       csN,       // chip select, active low
	input wire logic [3:0] hostSio,   // host values
	input wire logic [3:0] hostSioOe, // host enables
	input wire logic [3:0] devSio,    // device values
	input wire logic [3:0] devSioOe,  // device enables
	input wire logic [3:0] sio        // resolved lines
);
	logic        sclkQ;
	logic [11:0] riseCnt;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// rises per frame; dual data makes bytes of four rises
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			sclkQ   <= 1'b0;
			riseCnt <= 12'h0;
		end
		else
		begin
			sclkQ <= sclk;
			if (csN)
				riseCnt <= 12'h0;
			else if (sclk && !sclkQ)
				riseCnt <= riseCnt + 12'h1;
		end
	end
	a_idle_clock_low: assert property (csN |-> !sclk)
		else $error("serial clock high while deselected");
	a_sclk_high_time: assert property ($rose(sclk) |-> sclk[*8] ##1 !sclk)
		else $error("serial clock high phase length");
	a_sclk_low_time: assert property ($fell(sclk) |-> !sclk[*8])
		else $error("serial clock low phase too short");
	a_data_hold_high: assert property (sclk && $past(sclk) |-> $stable(hostSio[1:0]))
		else $error("data changed while clock high");
	a_upper_lines_free: assert property (hostSioOe[3:2] == 2'h0 && devSioOe[3:2] == 2'h0)
		else $error("upper data lines driven");
	a_si_driven: assert property (sclk |-> !csN && hostSioOe[0])
		else $error("input line not driven in frame");
	a_frame_bytes: assert property ($rose(csN) |-> riseCnt[1:0] == 2'h0 && riseCnt >= 12'h8)
		else $error("select released off a byte boundary");
	a_dual_after_addr: assert property (hostSioOe[1] |-> riseCnt >= 12'h20)
		else $error("second line driven before data bytes");
	a_dev_release: assert property ($rose(csN) |-> ##6 devSioOe == 4'h0)
		else $error("device still driving after frame");
	a_status_resolve: assert property (devSioOe[1] |-> sio[1] == devSio[1])
		else $error("status line not resolved to device");
	c_dual_frame: cover property (hostSioOe[1]);
	c_status_out: cover property (devSioOe[1]);
	c_addr_frame: cover property ($rose(csN) && riseCnt == 12'h20);
endmodule : sfe_link_asserts

/* File: bench/sfe_flash_bench.sv */
// self-checking bench joining host and device ends of the flash link
`timescale 1ns/1ps
module sfe_flash_bench;
	logic        clk_sys;
	logic        rst;
	logic        cmdValid;
	logic        cmdReady;
	logic [7:0]  cmdOp;
	logic [23:0] cmdAddr;
	logic [8:0]  cmdLen;
	logic        wrTake;
	logic [7:0]  wrData;
	logic        rdValid;
	logic [7:0]  rdData;
	logic [4:0]  blockProtect;
	logic [15:0] peekAddr;
	logic [7:0]  peekData;
	logic        wipFlag;
	logic        welFlag;
	int          wIdx;
	int          rdSeen;
	int          n_mismatch;
	int          check_count;
	int          cycles;
	sfe_link_if link ();
	sfe_flash_host #(.HALF_DIV(8)) sfe_flash_host_i (.clk_sys(clk_sys), .rst(rst),
		.link(link.host), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp),
		.cmdAddr(cmdAddr), .cmdLen(cmdLen), .wrTake(wrTake), .wrData(wrData),
		.rdValid(rdValid), .rdData(rdData));
	sfe_flash_dev #(.ADDR_W(16)) sfe_flash_dev_i (.clk_sys(clk_sys), .rst(rst),
		.link(link.dev), .blockProtect(blockProtect), .peekAddr(peekAddr),
		.peekData(peekData), .wipFlag(wipFlag), .welFlag(welFlag));
	sfe_link_asserts sfe_link_asserts_i (.clk_sys(clk_sys), .rst(rst), .sclk(link.sclk),
		.csN(link.csN), .hostSio(link.hostSio), .hostSioOe(link.hostSioOe),
		.devSio(link.devSio), .devSioOe(link.devSioOe), .sio(link.sio));
	// byte k of a program stream; pairs repeat so overwrite and AND differ
	function automatic logic [7:0] dataAt(input int k);
		return 8'ha5 ^ 8'(k >> 1);
	endfunction : dataAt
	assign wrData = dataAt(wIdx);
	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys)
		if (wrTake === 1'b1)
			wIdx <= wIdx + 1;
	always @(posedge clk_sys)
		if (rst)
			rdSeen <= 0;
		else if (rdValid === 1'b1)
			rdSeen <= rdSeen + 1;
	// longest run is one 32K-class wait plus a 257-byte frame
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 98000)
		begin
			n_mismatch++;
			summarize();
		end
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : summarize
	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		check_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : check
	task automatic flags(input logic write_in_progress_flag, input logic write_enable_latch, input string what);
		check({6'h0, wipFlag, welFlag}, {6'h0, write_in_progress_flag, write_enable_latch}, what);
	endtask : flags
	task automatic issue(input logic [7:0] op, input logic [23:0] addr, input logic [8:0] len);
		int n;
		@(posedge clk_sys);
		wIdx     <= 0;
		cmdValid <= 1'b1;
		cmdOp    <= op;
		cmdAddr  <= addr;
		cmdLen   <= len;
		@(posedge clk_sys);
		cmdValid <= 1'b0;
		n = 0;
		@(negedge clk_sys);
		while (cmdReady !== 1'b1 && n < 40000)
		begin
			@(negedge clk_sys);
			n++;
		end
		if (n == 40000)
			check(8'h0, 8'h1, "frame hang");
	endtask : issue
	task automatic write_enable_cmd();
		issue(sfe_pkg::OP_WRITE_ENABLE, 24'h0, 9'h0);
	endtask : write_enable_cmd
	task automatic waitIdle();
		int n;
		n = 0;
		while (wipFlag !== 1'b0 && n < 40000)
		begin
			@(negedge clk_sys);
			n++;
		end
		if (n == 40000)
			check(8'h0, 8'h1, "busy hang");
	endtask : waitIdle
	task automatic peek(input logic [15:0] a, input logic [7:0] exp, input string what);
		@(posedge clk_sys);
		peekAddr <= a;
		@(posedge clk_sys);
		@(negedge clk_sys);
		check(peekData, exp, what);
	endtask : peek
	task automatic t_no_latch();
		issue(sfe_pkg::OP_PAGE_WRITE, 24'h00f000, 9'h1);
		flags(1'b0, 1'b0, "program w/o latch");
		issue(sfe_pkg::OP_BLOCK_ERASE, 24'h00f000, 9'h0);
		flags(1'b0, 1'b0, "block erase w/o latch");
		issue(sfe_pkg::OP_CHIP_ERASE_A, 24'h0, 9'h0);
		flags(1'b0, 1'b0, "chip erase a w/o latch");
		issue(sfe_pkg::OP_CHIP_ERASE_B, 24'h0, 9'h0);
		flags(1'b0, 1'b0, "chip erase b w/o latch");
	endtask : t_no_latch
	task automatic t_sector();
		write_enable_cmd();
		flags(1'b0, 1'b1, "latch set");
		issue(sfe_pkg::OP_SECTOR_ERASE, 24'h00f123, 9'h0);
		flags(1'b1, 1'b1, "sector busy");
		waitIdle();
		flags(1'b0, 1'b0, "sector done");
		peek(16'hf000, 8'hff, "sector low end");
		peek(16'hffff, 8'hff, "sector high end");
	endtask : t_sector
	task automatic t_program();
		write_enable_cmd();
		issue(sfe_pkg::OP_PAGE_WRITE, 24'h00f0fe, 9'h3);
		flags(1'b1, 1'b1, "program busy");
		waitIdle();
		flags(1'b0, 1'b0, "program done");
		peek(16'hf0fe, dataAt(0), "first byte");
		peek(16'hf000, dataAt(2), "wrapped byte");
		peek(16'hf001, 8'hff, "untouched byte");
	endtask : t_program
	task automatic t_dual();
		write_enable_cmd();
		issue(sfe_pkg::OP_TWO_LINE_WRITE, 24'h00f000, 9'h2);
		waitIdle();
		peek(16'hf000, dataAt(2) & dataAt(0), "bits only cleared");
		peek(16'hf001, dataAt(1), "dual byte");
	endtask : t_dual
	task automatic t_long();
		write_enable_cmd();
		issue(sfe_pkg::OP_PAGE_WRITE, 24'h00f100, 9'h101);
		waitIdle();
		peek(16'hf100, dataAt(256), "last byte kept");
		peek(16'hf1ff, dataAt(255), "page end byte");
	endtask : t_long
	task automatic t_page_erase();
		write_enable_cmd();
		issue(sfe_pkg::OP_PAGE_WRITE, 24'h00f0fe, 9'h0);
		flags(1'b0, 1'b1, "empty program");
		issue(sfe_pkg::OP_PAGE_ERASE, 24'h00f0ab, 9'h0);
		flags(1'b1, 1'b1, "page erase busy");
		waitIdle();
		peek(16'hf000, 8'hff, "page start erased");
		peek(16'hf0fe, 8'hff, "page end erased");
		peek(16'hf100, dataAt(256), "next page kept");
	endtask : t_page_erase
	task automatic t_protect();
		@(posedge clk_sys);
		blockProtect <= 5'h01;
		write_enable_cmd();
		issue(sfe_pkg::OP_SECTOR_ERASE, 24'h00f100, 9'h0);
		flags(1'b1, 1'b1, "protected busy");
		// unprotect so only the busy refusal keeps the target byte intact
		@(posedge clk_sys);
		blockProtect <= 5'h00;
		issue(sfe_pkg::OP_PAGE_WRITE, 24'h00f1fe, 9'h1);
		issue(sfe_pkg::OP_READ_STATUS, 24'h0, 9'h0);
		check(rdData, 8'h03, "status while busy");
		check(8'(rdSeen), 8'h01, "status pulse");
		waitIdle();
		flags(1'b0, 1'b0, "protected done");
		peek(16'hf100, dataAt(256), "protected kept");
		peek(16'hf1fe, dataAt(254), "busy program refused");
	endtask : t_protect
	task automatic t_half();
		write_enable_cmd();
		issue(sfe_pkg::OP_HALF_BLOCK_ERASE, 24'h009abc, 9'h0);
		flags(1'b1, 1'b1, "half block busy");
		waitIdle();
		flags(1'b0, 1'b0, "half block done");
		peek(16'h8000, 8'hff, "half block start");
		peek(16'hf100, 8'hff, "half block top");
	endtask : t_half
	initial
	begin
		rst          = 1'b1;
		cmdValid     = 1'b0;
		cmdOp        = 8'h0;
		cmdAddr      = 24'h0;
		cmdLen       = 9'h0;
		blockProtect = 5'h0;
		peekAddr     = 16'h0;
		wIdx         = 0;
		n_mismatch   = 0;
		check_count  = 0;
		cycles       = 0;
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (4) @(posedge clk_sys);
		t_no_latch();
		t_sector();
		t_program();
		t_dual();
		t_long();
		t_page_erase();
		t_protect();
		t_half();
		summarize();
	end
endmodule : sfe_flash_bench
